// *** gspd_top.sv ***
// SPI status write decoder with global protect and sector lock, APB view.
//
// Operation
// - A permitted write with the lock clear and bits 5..2 all one protects every sector.
// - A permitted write with the lock clear and bits 5..2 all zero unprotects every sector.
// - Other patterns of bits 5..2 keep protection; bits 6, 1, 0 are ignored.
// - With the pin low and the lock set, a status write only clears the write enable latch.
// - With the pin high and the lock set, only bit 7 may clear the lock.
// - With the lock clear, the lock is loaded from bit 7 whatever the pin.
// - With the lock clear, 00h unprotects and 7Fh protects all, lock clear.
// - Writing 0Fh with the pin high clears the lock, protection untouched.
// - Writing F0h sets the lock from zero and leaves protection untouched.
// - Only bit 7 of a status write is stored; bits 5..2 are only decoded.
// - SPI status reads show pin and aggregate protection in bits 4..2.
// - Sector protect and unprotect keep working after a global operation.
// - A status write runs only if the write enable latch was set before.
// - Power-up or device reset protects every sector.
// - Hardware locking is active only with the pin low and the lock set.
`timescale 1ns/1ns
module gspd_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	input wire logic wp_n,
	output logic spi_so,
	output logic spi_so_oe
);

	logic [2:0] sck_s;
	logic [2:0] cs_s;
	logic [1:0] si_s;
	logic [1:0] wp_s;
	logic [7:0] shift_r;
	logic [2:0] bit_r;
	logic [2:0] byte_r;
	logic [7:0] opcode_r;
	logic [7:0] wdata_r;
	logic [3:0] sect_r;
	logic [23:0] addr_r;
	logic [15:0] prot_r;
	logic lock_r;
	logic wren_latch_r;
	logic so_r;
	logic so_oe_r;
	logic [31:0] prdata_r;
	logic [7:0] shift_nxt;
	logic sck_rise;
	logic sck_fall;
	logic cs_active;
	logic cs_end;
	logic wp_level;
	logic hw_locked;
	logic wrsr_go;
	logic wrsr_ok;
	logic sect_go;
	logic apb_wr;
	logic apb_rd;
	logic dev_rst;
	logic [7:0] status;
	logic [7:0] out_byte;
	logic out_phase;

	function automatic logic [1:0] swp_code(input logic [15:0] p);
		swp_code = (&p) ? 2'b11 : ((|p) ? 2'b01 : 2'b00);
	endfunction

	// Pin inputs pass two flops; the third sck and cs stage feeds edge detect.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s <= 3'h0;
			cs_s <= 3'h7;
			si_s <= 2'h0;
			wp_s <= 2'h3;
		end else begin
			sck_s <= {sck_s[1:0], spi_sck};
			cs_s <= {cs_s[1:0], spi_cs_n};
			si_s <= {si_s[0], spi_si};
			wp_s <= {wp_s[0], wp_n};
		end
	end

	assign cs_active = !cs_s[1];
	assign cs_end = cs_s[1] && !cs_s[2];
	assign sck_rise = cs_active && sck_s[1] && !sck_s[2];
	assign sck_fall = cs_active && !sck_s[1] && sck_s[2];
	assign wp_level = wp_s[1];
	assign shift_nxt = {shift_r[6:0], si_s[1]};
	assign hw_locked = lock_r && !wp_level;

	// Bits are taken on rising sck; bytes counted up to the address end.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_r <= 8'h00;
			bit_r <= 3'h0;
			byte_r <= 3'h0;
		end else if (!cs_active) begin
			bit_r <= 3'h0;
			byte_r <= 3'h0;
		end else if (sck_rise) begin
			shift_r <= shift_nxt;
			bit_r <= bit_r + 3'h1;
			if (bit_r == 3'h7 && byte_r != gspd_pkg::BYTES_MAX) begin
				byte_r <= byte_r + 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opcode_r <= 8'h00;
			wdata_r <= 8'h00;
			addr_r <= 24'h00_0000;
		end else if (sck_rise && bit_r == 3'h7) begin
			case (byte_r)
				3'h0: opcode_r <= shift_nxt;
				3'h1: begin
					wdata_r <= shift_nxt;
					addr_r[23:16] <= shift_nxt;
				end
				3'h2: addr_r[15:8] <= shift_nxt;
				3'h3: addr_r[7:0] <= shift_nxt;
				default: addr_r <= addr_r;
			endcase
		end
	end

	assign sect_r = addr_r[gspd_pkg::SECT_ADDR_LO +: 4];

	assign wrsr_go = cs_end && opcode_r == gspd_pkg::OP_WRSR &&
		byte_r >= gspd_pkg::BYTES_WRSR;
	assign wrsr_ok = wrsr_go && wren_latch_r && !hw_locked;
	assign sect_go = cs_end && byte_r >= gspd_pkg::BYTES_ADDR &&
		(opcode_r == gspd_pkg::OP_PROT || opcode_r == gspd_pkg::OP_UNPROT);

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;
	assign dev_rst = apb_wr && paddr == gspd_pkg::OFF_CTRL &&
		pwdata[gspd_pkg::CTRL_DEV_RESET];

	// Sector protection: global decode at chip select end, or one sector.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot_r <= gspd_pkg::PROT_RESET;
		end else if (dev_rst) begin
			prot_r <= gspd_pkg::PROT_RESET;
		end else if (wrsr_ok && !lock_r) begin
			if (wdata_r[5:2] == gspd_pkg::GLOBAL_ALL_ONE) begin
				prot_r <= gspd_pkg::PROT_RESET;
			end else if (wdata_r[5:2] == gspd_pkg::GLOBAL_ALL_ZERO) begin
				prot_r <= 16'h0000;
			end
		end else if (sect_go && wren_latch_r && !lock_r) begin
			prot_r[sect_r] <= (opcode_r == gspd_pkg::OP_PROT);
		end
	end

	// Only bit 7 is stored; a set lock can only be cleared here.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_r <= gspd_pkg::LOCK_RESET;
		end else if (dev_rst) begin
			lock_r <= gspd_pkg::LOCK_RESET;
		end else if (wrsr_ok) begin
			lock_r <= wdata_r[gspd_pkg::SR_LOCK];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wren_latch_r <= 1'b0;
		end else if (dev_rst) begin
			wren_latch_r <= 1'b0;
		end else if (cs_end) begin
			case (opcode_r)
				gspd_pkg::OP_WREN: begin
					if (byte_r >= gspd_pkg::BYTES_OP) begin
						wren_latch_r <= 1'b1;
					end
				end
				gspd_pkg::OP_WRDI: begin
					if (byte_r >= gspd_pkg::BYTES_OP) begin
						wren_latch_r <= 1'b0;
					end
				end
				gspd_pkg::OP_WRSR,
				gspd_pkg::OP_PROT,
				gspd_pkg::OP_UNPROT: begin
					if (byte_r >= gspd_pkg::BYTES_OP) begin
						wren_latch_r <= 1'b0;
					end
				end
				default: wren_latch_r <= wren_latch_r;
			endcase
		end
	end

	// Bits 4..2 show pin and protection state, never written data.
	always_comb begin
		status = 8'h00;
		status[gspd_pkg::SR_LOCK] = lock_r;
		status[gspd_pkg::SR_WPP] = wp_level;
		status[gspd_pkg::SR_SWP_HI:gspd_pkg::SR_SWP_LO] = swp_code(prot_r);
		status[gspd_pkg::SR_WREN_LATCH] = wren_latch_r;
	end

	always_comb begin
		out_byte = 8'h00;
		out_phase = 1'b0;
		if (opcode_r == gspd_pkg::OP_RDSR && byte_r >= gspd_pkg::BYTES_OP) begin
			out_byte = status;
			out_phase = 1'b1;
		end else if (opcode_r == gspd_pkg::OP_RDPROT &&
			byte_r >= gspd_pkg::BYTES_ADDR) begin
			out_byte = prot_r[sect_r] ? 8'hFF : 8'h00;
			out_phase = 1'b1;
		end
	end

	// Serial output changes on falling sck, most significant bit first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else if (!cs_active) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else if (sck_fall && out_phase) begin
			so_r <= out_byte[3'h7 - bit_r];
			so_oe_r <= 1'b1;
		end
	end

	assign spi_so = so_r;
	assign spi_so_oe = so_oe_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= gspd_pkg::RDATA_NONE;
		end else if (apb_rd) begin
			prdata_r <= gspd_pkg::RDATA_NONE;
			if (paddr == gspd_pkg::OFF_STATUS) begin
				prdata_r[15:0] <= prot_r;
				prdata_r[gspd_pkg::AST_LOCK] <= lock_r;
				prdata_r[gspd_pkg::AST_WREN_LATCH] <= wren_latch_r;
				prdata_r[gspd_pkg::AST_WPP] <= wp_level;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && paddr != gspd_pkg::OFF_STATUS &&
		paddr != gspd_pkg::OFF_CTRL;

	a_global_protect: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_ok && !lock_r && !dev_rst &&
		wdata_r[5:2] == 4'hF |=> prot_r == 16'hFFFF)
		else $error("global protect did not set all sectors");
	a_global_unprot: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_ok && !lock_r && !dev_rst &&
		wdata_r[5:2] == 4'h0 |=> prot_r == 16'h0000)
		else $error("global unprotect did not clear all sectors");
	a_partial_keep: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_go && !dev_rst &&
		wdata_r[5:2] != 4'hF && wdata_r[5:2] != 4'h0 |=> $stable(prot_r))
		else $error("partial pattern changed protection");
	a_hard_lock: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_go && !dev_rst && lock_r && !wp_level
		|=> $stable(prot_r) && $stable(lock_r))
		else $error("hard lock was bypassed");
	a_soft_lock: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_go && !dev_rst && lock_r && wp_level &&
		wren_latch_r |=> $stable(prot_r) && lock_r == $past(wdata_r[7]))
		else $error("soft lock handling wrong");
	a_lock_load: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_go && !dev_rst && !lock_r && wren_latch_r
		|=> lock_r == $past(wdata_r[7]))
		else $error("lock bit not loaded from bit 7");
	a_latch_needed: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_go && !dev_rst && !wren_latch_r
		|=> $stable(prot_r) && $stable(lock_r))
		else $error("status write ran without write enable");
	a_dev_reset: assert property (@(posedge pclk)
		disable iff (!presetn) dev_rst
		|=> prot_r == 16'hFFFF && !lock_r && !wren_latch_r)
		else $error("device reset did not protect all sectors");
	a_latch_clear: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_go && !dev_rst
		|=> !wren_latch_r)
		else $error("write enable latch not cleared after status write");
	a_clear_unprot: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_ok && !dev_rst && !lock_r &&
		wdata_r == 8'h00 |=> prot_r == 16'h0000 && !lock_r)
		else $error("write of 00h did not unprotect with lock clear");
	a_clear_prot: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_ok && !dev_rst && !lock_r &&
		wdata_r == 8'h7F |=> prot_r == 16'hFFFF && !lock_r)
		else $error("write of 7Fh did not protect with lock clear");
	a_soft_unlock: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_ok && !dev_rst && lock_r &&
		wdata_r == 8'h0F |=> !lock_r && $stable(prot_r))
		else $error("write of 0Fh did not only clear the lock");
	a_lock_set: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_ok && !dev_rst && !lock_r &&
		wdata_r == 8'hF0 |=> lock_r && $stable(prot_r))
		else $error("write of F0h did not only set the lock");
	a_bit7_stored: assert property (@(posedge pclk)
		disable iff (!presetn) wrsr_ok && !dev_rst
		|=> lock_r == $past(wdata_r[7]))
		else $error("stored lock differs from written bit 7");
	a_status_swp: assert property (@(posedge pclk)
		disable iff (!presetn) status[3:2] == ((prot_r == 16'hFFFF) ? 2'b11 :
		((prot_r == 16'h0000) ? 2'b00 : 2'b01)))
		else $error("status aggregate protection field wrong");
	a_status_pin: assert property (@(posedge pclk)
		disable iff (!presetn) status[4] == wp_level &&
		status[7] == lock_r && status[6] == 1'b0)
		else $error("status pin or lock field wrong");
	a_sector_write: assert property (@(posedge pclk)
		disable iff (!presetn) sect_go && !dev_rst && wren_latch_r && !lock_r
		|=> prot_r[$past(sect_r)] == ($past(opcode_r) == 8'h36))
		else $error("single sector command did not take effect");
	a_sector_locked: assert property (@(posedge pclk)
		disable iff (!presetn) sect_go && !dev_rst && hw_locked
		|=> $stable(prot_r))
		else $error("sector changed while hardware locked");
	a_update_at_end: assert property (@(posedge pclk)
		disable iff (!presetn) !cs_end && !dev_rst
		|=> $stable(prot_r) && $stable(lock_r))
		else $error("protection changed outside chip select end");
	a_sector_latch: assert property (@(posedge pclk)
		disable iff (!presetn) sect_go && !dev_rst && !wren_latch_r
		|=> $stable(prot_r))
		else $error("sector command ran without write enable");

endmodule // gspd_top

// *** gspd_pkg.sv ***
// Constants for the global sector protection decoder.
package gspd_pkg;
	localparam int NSECT = 16;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_PROT = 8'h36;
	localparam logic [7:0] OP_UNPROT = 8'h39;
	localparam logic [7:0] OP_RDPROT = 8'h3C;
	localparam logic [3:0] GLOBAL_ALL_ONE = 4'hF;
	localparam logic [3:0] GLOBAL_ALL_ZERO = 4'h0;
	localparam int SR_LOCK = 7;
	localparam int SR_WPP = 4;
	localparam int SR_SWP_HI = 3;
	localparam int SR_SWP_LO = 2;
	localparam int SR_WREN_LATCH = 1;
	localparam int SECT_ADDR_LO = 17;
	localparam logic [2:0] BYTES_WRSR = 3'h2;
	localparam logic [2:0] BYTES_ADDR = 3'h4;
	localparam logic [2:0] BYTES_OP = 3'h1;
	localparam logic [2:0] BYTES_MAX = 3'h4;
	localparam logic [15:0] PROT_RESET = 16'hFFFF;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic [11:0] OFF_STATUS = 12'h000;
	localparam logic [11:0] OFF_CTRL = 12'h004;
	localparam int CTRL_DEV_RESET = 0;
	localparam int AST_LOCK = 16;
	localparam int AST_WREN_LATCH = 17;
	localparam int AST_WPP = 18;
	localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
endpackage

// *** gspd_spi_host.sv ***
// Behavioural SPI host that clocks flash commands into the block.
`timescale 1ns/1ns
module gspd_spi_host (
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	logic [7:0] rx;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		rx = 8'h00;
	end
	// Mode 0 frame, MSB first; the odd start offset keeps edges off pclk.
	task automatic xfer(input logic [39:0] d, input int nb);
		#7;
		cs_n = 1'b0;
		for (int i = nb * 8 - 1; i >= 0; i--) begin
			si = d[i];
			#160;
			sck = 1'b1;
			#159;
			rx = {rx[6:0], so};
			#1;
			sck = 1'b0;
		end
		#160;
		si = ~si;
		cs_n = 1'b1;
		#640;
	endtask
endmodule // gspd_spi_host

// *** global_sector_protect_decode_tb.sv ***
// Testbench for the global sector protection decoder.
`timescale 1ns/1ns
module global_sector_protect_decode_tb;
	localparam logic [31:0] M = 32'h0007_FFFF;
	localparam logic [31:0] L = 32'h0001_0000;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, wp_n = 1'b1, pready, pslverr, err;
	logic sck, cs_n, si, so, so_oe;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	int miscompares = 0, n_checks = 0;
	// Entry: [31] enable first, [30:23] data, [18:0] expected status.
	logic [31:0] tab [13] = '{32'h0000_FFFF, 32'h8004_0000,
		32'hBF84_FFFF, 32'h8004_0000, 32'hA384_0000, 32'h9D84_0000,
		32'hF805_0000, 32'h8001_0000, 32'hFF85_0000, 32'h8784_0000,
		32'h9E04_FFFF, 32'hFF81_FFFF, 32'h8001_FFFF};
	always #20 pclk = ~pclk;
	gspd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si),
		.wp_n(wp_n), .spi_so(so), .spi_so_oe(so_oe));
	gspd_spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			give_verdict();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic wrsr(input logic [7:0] d, input logic wren);
		if (wren)
			host.xfer({24'h00_0000, gspd_pkg::OP_WREN}, 1);
		host.xfer({16'h0000, gspd_pkg::OP_WRSR, d}, 2);
	endtask
	initial begin
		#2000000;
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(1'b0, gspd_pkg::OFF_STATUS, 32'h0000_0000);
		check("reset", rd, 32'h0004_FFFF);
		foreach (tab[i]) begin
			@(posedge pclk);
			wp_n <= tab[i][18];
			repeat (4) @(posedge pclk);
			wrsr(tab[i][30:23], tab[i][31]);
			apb(1'b0, gspd_pkg::OFF_STATUS, 32'h0000_0000);
			check("status", rd & M, tab[i] & M);
			check("lock", rd & L, tab[i] & L);
			$display("step %0d done", i);
		end
		apb(1'b1, gspd_pkg::OFF_CTRL, 32'h0000_0001);
		apb(1'b0, gspd_pkg::OFF_STATUS, 32'h0000_0000);
		check("dev reset", rd, 32'h0000_FFFF);
		$display("device reset done");
		@(posedge pclk);
		wp_n <= 1'b1;
		repeat (4) @(posedge pclk);
		wrsr(8'h00, 1'b1);
		host.xfer({24'h00_0000, gspd_pkg::OP_WREN}, 1);
		host.xfer({gspd_pkg::OP_PROT, 24'h06_0000}, 4);
		apb(1'b0, gspd_pkg::OFF_STATUS, 32'h0000_0000);
		check("sector", rd, 32'h0004_0008);
		host.xfer({16'h0000, gspd_pkg::OP_RDSR, 8'h00}, 2);
		check("spi status", {24'h00_0000, host.rx}, 32'h0000_0014);
		check("so released", {31'h0000_0000, so_oe}, 32'h0000_0000);
		host.xfer({gspd_pkg::OP_RDPROT, 24'h06_0000, 8'h00}, 5);
		check("spi sector", {24'h00_0000, host.rx}, 32'h0000_00FF);
		host.xfer({24'h00_0000, gspd_pkg::OP_WREN}, 1);
		apb(1'b0, gspd_pkg::OFF_STATUS, 32'h0000_0000);
		check("latch set", rd, 32'h0006_0008);
		host.xfer({24'h00_0000, gspd_pkg::OP_WRDI}, 1);
		apb(1'b0, gspd_pkg::OFF_STATUS, 32'h0000_0000);
		check("latch clear", rd, 32'h0004_0008);
		$display("sector and read done");
		apb(1'b0, 12'h008, 32'h0000_0000);
		check("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
		check("unmapped data", rd, 32'h0000_0000);
		$display("unmapped done");
		give_verdict();
	end
endmodule // global_sector_protect_decode_tb
